// ===== rtl/core_alu.sv
// Combinational 8-bit ALU feeding the accumulator, index and flag updates.
// Assumes the caller registers every result it keeps.
`timescale 1ns/1ps
module core_alu #(
  parameter int DW = 8
) (
  input  wire logic [DW-1:0]          a,
  input  wire logic [DW-1:0]          b,
  input  wire logic                   c_in,
  input  wire core_regs_pkg::alu_fn_t fn,
  output logic      [DW-1:0]          res,
  output logic                        c_out,
  output logic                        c_wr,
  output logic                        z_wr
);
  import core_regs_pkg::*;

  logic [DW:0] wide; // Sum with carry out on top

  // ----------------------------------------------------------------
  // Function select
  // ----------------------------------------------------------------
  // Each function states its own effect on zero and carry
  always_comb begin
    wide  = '0;
    res   = b;
    c_out = c_in;
    c_wr  = 1'b0;
    z_wr  = 1'b0;
    case (fn)
      ALU_ADD, ALU_ADC: begin
        wide  = {1'b0, a} + {1'b0, b} + {{DW{1'b0}}, fn == ALU_ADC && c_in};
        res   = wide[DW-1:0];
        c_out = wide[DW];
        c_wr  = 1'b1;
        z_wr  = 1'b1;
      end
      ALU_SUB, ALU_SBB: begin
        wide  = {1'b0, a} - {1'b0, b} - {{DW{1'b0}}, fn == ALU_SBB && c_in};
        res   = wide[DW-1:0];
        c_out = wide[DW];      // Borrow reads as carry
        c_wr  = 1'b1;
        z_wr  = 1'b1;
      end
      // Logic ops leave carry alone
      ALU_AND: begin
        res  = a & b;
        z_wr = 1'b1;
      end
      ALU_OR: begin
        res  = a | b;
        z_wr = 1'b1;
      end
      ALU_XOR: begin
        res  = a ^ b;
        z_wr = 1'b1;
      end
      // Shifts act on the source operand
      ALU_ASL: begin
        res   = {b[DW-2:0], 1'b0};
        c_out = b[DW-1];
        c_wr  = 1'b1;
        z_wr  = 1'b1;
      end
      ALU_ASR: begin
        res   = {b[DW-1], b[DW-1:1]};
        c_out = b[0];
        c_wr  = 1'b1;
        z_wr  = 1'b1;
      end
      ALU_RLC: begin
        res   = {b[DW-2:0], c_in};
        c_out = b[DW-1];
        c_wr  = 1'b1;
        z_wr  = 1'b1;
      end
      ALU_RRC: begin
        res   = {c_in, b[DW-1:1]};
        c_out = b[0];
        c_wr  = 1'b1;
        z_wr  = 1'b1;
      end
      default: begin
        res = b;               // Plain move, no flag effect
      end
    endcase
  end

endmodule : core_alu

// ===== rtl/core_regs_cfg.svh
// Constants for the CPU core register set: addresses, bit positions,
// reset values and stack adjustments.
// Assumes it is included by its bare name from the design files.
`ifndef CORE_REGS_CFG_SVH
`define CORE_REGS_CFG_SVH

// ----------------------------------------------------------------
// Register space
// ----------------------------------------------------------------
`define CRS_FLAGS_ADDR     8'hF7
`define CRS_UNMAPPED_DATA  8'h00

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define CRS_F_GIE          0
`define CRS_F_ZERO         1
`define CRS_F_CARRY        2
`define CRS_F_SUPER        3
`define CRS_F_BANK         4

// Bits that OR F / AND F may alter (super and reserved excluded)
`define CRS_F_WR_MASK      8'h17

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CRS_FLAGS_RST      8'h02
`define CRS_BYTE_RST       8'h00
`define CRS_PC_RST         16'h0000

// ----------------------------------------------------------------
// Stack adjustments per instruction
// ----------------------------------------------------------------
`define CRS_SP_PUSH        8'h01
`define CRS_SP_CALL        8'h02
`define CRS_SP_RET         8'h02
`define CRS_SP_RETI        8'h03

`endif

// ===== rtl/core_regs_pkg.sv
// Types shared by the CPU core register set and its ALU.
// Assumes core_regs_cfg.svh holds every numeric constant.
package core_regs_pkg;

  // Instruction classes that touch the core registers
  typedef enum logic [3:0] {
    OP_NOP,
    OP_ALU_A,
    OP_ALU_X,
    OP_MOV_X,
    OP_PUSH,
    OP_POP,
    OP_CALL,
    OP_LCALL,
    OP_JMP,
    OP_RET,
    OP_RETI,
    OP_ADD_SP,
    OP_SWAP_SP,
    OP_OR_F,
    OP_AND_F
  } op_t;

  // ALU functions; MOV passes the source through
  typedef enum logic [3:0] {
    ALU_MOV,
    ALU_ADD,
    ALU_ADC,
    ALU_SUB,
    ALU_SBB,
    ALU_AND,
    ALU_OR,
    ALU_XOR,
    ALU_ASL,
    ALU_ASR,
    ALU_RLC,
    ALU_RRC
  } alu_fn_t;

endpackage : core_regs_pkg

// ===== rtl/cpu_core_register_set.sv
// Core register set: flags, program counter, accumulator, stack
// pointer and index, updated as instruction side effects; the super flag follows its entry/exit pins.
// Assumes the decoder on sys_clk issues one op per valid cycle with
// its source data already fetched; flags read back only at 0xF7.
`timescale 1ns/1ps
`include "core_regs_cfg.svh"
module cpu_core_register_set #(
  parameter int DW = 8,   // Datapath width
  parameter int PW = 16,  // Program counter width
  parameter int PM = 13   // Program address bits (8 Kbytes)
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire logic                    op_valid,
  input  wire core_regs_pkg::op_t      op_code,
  input  wire core_regs_pkg::alu_fn_t  alu_fn,
  input  wire logic [DW-1:0]           operand,
  input  wire logic                    op_indexed,
  input  wire logic [DW-1:0]           src_data,
  input  wire logic [PW-1:0]           jump_target,
  input  wire logic [1:0]              instr_len,
  input  wire logic                    super_enter,
  input  wire logic                    super_exit,
  input  wire logic                    irq_pending,
  input  wire logic                    reg_rd_en,
  input  wire logic [DW-1:0]           reg_rd_addr,
  output logic      [DW-1:0]           accumulator_q,
  output logic      [DW-1:0]           index_offset_q,
  output logic      [DW-1:0]           stack_top_pointer_q,
  output logic      [DW-1:0]           processor_flags_q,
  output logic      [DW-1:0]           program_counter_high_q,
  output logic      [DW-1:0]           program_counter_low_q,
  output logic      [PM-1:0]           prog_addr_q,
  output logic      [DW-1:0]           oper_addr_q,
  output logic                         global_interrupt_enable_q,
  output logic                         register_bank_select_q,
  output logic                         irq_accept_q,
  output logic      [DW-1:0]           reg_rd_data_q
);
  import core_regs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [DW-1:0] acc_q, acc_d;           // Accumulator
  logic [DW-1:0] idx_q, idx_d;           // Index
  logic [DW-1:0] sp_q, sp_d;             // Stack pointer
  logic [DW-1:0] flg_q, flg_d;           // Flags
  logic [PW-1:0] pc_q, pc_d;             // Program counter
  logic [DW-1:0] addr_q, addr_d;         // Operand address
  logic          irqa_q, irqa_d;         // Interrupt accepted
  logic [DW-1:0] rdat_q, rdat_d;         // Register read data

  // ALU hookup
  logic [DW-1:0] alu_a;
  logic [DW-1:0] alu_res;
  logic          alu_c;
  logic          alu_cwr;
  logic          alu_zwr;

  // Flags reach the register space only at one address
  function automatic logic is_flags_addr(input logic [DW-1:0] a);
    return a == `CRS_FLAGS_ADDR;
  endfunction : is_flags_addr

  // ----------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------
  // X-destination ops work on index, all others on the accumulator
  assign alu_a = (op_code == OP_ALU_X) ? idx_q : acc_q;

  core_alu #(
    .DW (DW)
  ) u_alu (
    .a     (alu_a),
    .b     (src_data),
    .c_in  (flg_q[`CRS_F_CARRY]),
    .fn    (alu_fn),
    .res   (alu_res),
    .c_out (alu_c),
    .c_wr  (alu_cwr),
    .z_wr  (alu_zwr)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // No register-space write path exists at all, so the core set can only
  // move through the op decode and the super entry/exit pins below
  always_comb begin
    acc_d  = acc_q;
    idx_d  = idx_q;
    sp_d   = sp_q;
    flg_d  = flg_q;
    pc_d   = pc_q;
    addr_d = addr_q;
    // Indexed modes add X to the operand, else operand as is
    addr_d = op_indexed ? operand + idx_q : operand;
    if (op_valid) begin
      // Sequential fetch; wraps at 16 bits
      pc_d = pc_q + {{(PW-2){1'b0}}, instr_len};
      case (op_code)
        OP_ALU_A: begin
          acc_d = alu_res;
          if (alu_cwr) flg_d[`CRS_F_CARRY] = alu_c;
          if (alu_zwr) flg_d[`CRS_F_ZERO] = (alu_res == '0);
        end
        OP_ALU_X: begin
          idx_d = alu_res;
          if (alu_cwr) flg_d[`CRS_F_CARRY] = alu_c;
          if (alu_zwr) flg_d[`CRS_F_ZERO] = (alu_res == '0);
        end
        OP_MOV_X: begin
          idx_d = src_data;
        end
        // Stack traffic moves the top-of-stack address
        OP_PUSH: begin
          sp_d = sp_q + `CRS_SP_PUSH;
        end
        OP_POP: begin
          acc_d = src_data;
          sp_d  = sp_q - `CRS_SP_PUSH;
        end
        OP_CALL, OP_LCALL: begin
          sp_d = sp_q + `CRS_SP_CALL;
          pc_d = jump_target;
        end
        OP_JMP: begin
          pc_d = jump_target;
        end
        OP_RET: begin
          sp_d = sp_q - `CRS_SP_RET;
          pc_d = jump_target;
        end
        OP_RETI: begin
          sp_d = sp_q - `CRS_SP_RETI;
          pc_d = jump_target;
        end
        OP_ADD_SP: begin
          sp_d = sp_q + src_data;
        end
        OP_SWAP_SP: begin
          sp_d  = acc_q;
          acc_d = sp_q;
        end
        // Only the masked bits move; super and reserved hold
        OP_OR_F: begin
          flg_d = flg_q | (src_data & `CRS_F_WR_MASK);
        end
        OP_AND_F: begin
          flg_d = flg_q & (src_data | ~`CRS_F_WR_MASK);
        end
        default: begin
          flg_d = flg_q;                            // No core effect
        end
      endcase
    end
    // Super bit follows the hardware entry/exit pins only
    if (super_enter) begin
      flg_d[`CRS_F_SUPER] = 1'b1;
    end else if (super_exit) begin
      flg_d[`CRS_F_SUPER] = 1'b0;
    end
    // Reserved bits always read zero
    flg_d[DW-1:`CRS_F_BANK+1] = '0;
  end

  // Interrupt gate and register-space readback
  always_comb begin
    irqa_d = irq_pending & flg_q[`CRS_F_GIE];
    rdat_d = rdat_q;
    // Unmapped reads answer zero; of the core set only the flags are visible
    if (reg_rd_en) begin
      rdat_d = is_flags_addr(reg_rd_addr) ? flg_q : `CRS_UNMAPPED_DATA;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset leaves only the zero flag set
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      acc_q  <= `CRS_BYTE_RST;
      idx_q  <= `CRS_BYTE_RST;
      sp_q   <= `CRS_BYTE_RST;
      flg_q  <= `CRS_FLAGS_RST;
      pc_q   <= `CRS_PC_RST;
      addr_q <= `CRS_BYTE_RST;
      irqa_q <= 1'b0;
      rdat_q <= `CRS_BYTE_RST;
    end else begin
      acc_q  <= acc_d;
      idx_q  <= idx_d;
      sp_q   <= sp_d;
      flg_q  <= flg_d;
      pc_q   <= pc_d;
      addr_q <= addr_d;
      irqa_q <= irqa_d;
      rdat_q <= rdat_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign accumulator_q             = acc_q;
  assign index_offset_q            = idx_q;
  assign stack_top_pointer_q       = sp_q;
  assign processor_flags_q         = flg_q;
  assign program_counter_high_q    = pc_q[PW-1:DW];
  assign program_counter_low_q     = pc_q[DW-1:0];
  assign prog_addr_q               = pc_q[PM-1:0];
  assign oper_addr_q               = addr_q;
  assign global_interrupt_enable_q = flg_q[`CRS_F_GIE];
  assign register_bank_select_q    = flg_q[`CRS_F_BANK];
  assign irq_accept_q              = irqa_q;
  assign reg_rd_data_q             = rdat_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_push;
    op_valid && op_code == OP_PUSH;
  endsequence
  sequence s_swap;
    op_valid && op_code == OP_SWAP_SP;
  endsequence
  sequence s_call;
    op_valid && (op_code == OP_CALL || op_code == OP_LCALL);
  endsequence
  sequence s_ret;
    op_valid && op_code == OP_RET;
  endsequence

  AST_RESET_VALUES: assert property (
    disable iff (1'b0) !rstn |=> flg_q == 8'h02 && acc_q == 8'h00 &&
      pc_q == 16'h0000 && sp_q == 8'h00 && idx_q == 8'h00)
    else $error("Reset values wrong");

  AST_RESERVED_ZERO: assert property (
    flg_q[7:5] == 3'b000)
    else $error("Reserved flag bits set");

  AST_SUPER_HOLD: assert property (
    !super_enter && !super_exit |=> $stable(flg_q[3]))
    else $error("Super bit changed without hardware cause");

  AST_PUSH_SP: assert property (
    s_push ##1 s_push |=> sp_q == $past(sp_q, 2) + 8'h02)
    else $error("Two pushes did not advance pointer by two");

  AST_SWAP: assert property (
    s_swap |=> sp_q == $past(acc_q) && acc_q == $past(sp_q))
    else $error("Swap did not exchange");

  AST_IRQ_GATE: assert property (
    irq_accept_q |-> $past(flg_q[0]) && $past(irq_pending))
    else $error("Interrupt accepted while disabled");

  AST_FLAG_READ: assert property (
    reg_rd_en && reg_rd_addr == 8'hF7 |=> reg_rd_data_q == $past(flg_q))
    else $error("Flag readback mismatch");

  AST_ZERO_FLAG: assert property (
    op_valid && op_code == OP_ALU_A && alu_fn == ALU_ADD
    |=> flg_q[1] == (acc_q == 8'h00))
    else $error("Zero flag does not match result");

  AST_PC_STEP: assert property (
    op_valid && op_code == OP_NOP |=> pc_q == $past(pc_q) + $past(instr_len))
    else $error("PC did not advance by length");

  // Bank select may only move through the two flag instructions
  AST_BANK: assert property (
    !(op_valid && (op_code == OP_OR_F || op_code == OP_AND_F))
    |=> $stable(register_bank_select_q))
    else $error("Bank select moved without a flag instruction");

  AST_OR_F: assert property (
    op_valid && op_code == OP_OR_F |=> (flg_q & 8'h17) ==
      (($past(flg_q) | $past(src_data)) & 8'h17))
    else $error("OR into flags gave wrong writable bits");

  AST_POP_SP: assert property (
    op_valid && op_code == OP_POP |=>
      sp_q == $past(sp_q) - 8'h01 && acc_q == $past(src_data))
    else $error("Pop did not retreat pointer and load accumulator");

  // A call followed at once by a return leaves the pointer unchanged
  AST_CALL_RET: assert property (
    s_call ##1 s_ret |=> sp_q == $past(sp_q, 2))
    else $error("Call then return did not restore pointer");

endmodule : cpu_core_register_set

// ===== sim/tb_cpu_core_register_set.sv
// Self-checking bench for the CPU core register set.
// Assumes the design package, cfg header and rtl are compiled first.
`timescale 1ns/1ps
`include "core_regs_cfg.svh"
module tb_cpu_core_register_set;
  import core_regs_pkg::*;

  // ------------------------------------------------------------
  // Compare helper: counts every check, reports any difference
  // ------------------------------------------------------------
  `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
    err_count++; $display("mismatch t=%0t got=%h exp=%h", \
    $time, g, e); end end

  // One expected snapshot of every output, due on a given cycle
  typedef struct {
    logic [7:0]  a, x, sp, f, oa, rd;
    logic [15:0] pc;
    logic        irq;
    int          due;
  } note_t;

  logic          sys_clk = 1'b0;    // 50 MHz system clock
  logic          rstn;               // Synchronous reset, active low
  logic          op_valid;
  op_t           op_code;
  alu_fn_t       alu_fn;
  logic [7:0]    operand, src_data, reg_rd_addr;
  logic          op_indexed, super_enter, super_exit;
  logic          irq_pending, reg_rd_en;
  logic [15:0]   jump_target;
  logic [1:0]    instr_len;
  logic [7:0]    acc, idx_q, sp_q, flg, pch, pcl, oa_q, rd_q;
  logic [12:0]   pa_q;
  logic          gie_q, bank_q, irq_q;
  int            err_count = 0;      // Mismatches seen
  int            cmp_count = 0;      // Comparisons made
  int            cyc = 0;            // Falling edges seen
  note_t         q[$];               // Expected results in order
  note_t         mon_n;              // Note under comparison
  logic [7:0]    ma, mx, msp, mf, mrd; // Reference register state
  logic [15:0]   mpc;

  always #10 sys_clk = ~sys_clk;

  cpu_core_register_set u_cpu_core_register_set (
    .sys_clk(sys_clk), .rstn(rstn), .op_valid(op_valid),
    .op_code(op_code), .alu_fn(alu_fn), .operand(operand),
    .op_indexed(op_indexed), .src_data(src_data),
    .jump_target(jump_target), .instr_len(instr_len),
    .super_enter(super_enter), .super_exit(super_exit),
    .irq_pending(irq_pending), .reg_rd_en(reg_rd_en),
    .reg_rd_addr(reg_rd_addr), .accumulator_q(acc),
    .index_offset_q(idx_q), .stack_top_pointer_q(sp_q),
    .processor_flags_q(flg), .program_counter_high_q(pch),
    .program_counter_low_q(pcl), .prog_addr_q(pa_q),
    .oper_addr_q(oa_q), .global_interrupt_enable_q(gie_q),
    .register_bank_select_q(bank_q), .irq_accept_q(irq_q),
    .reg_rd_data_q(rd_q));

  // ------------------------------------------------------------
  // Reference arithmetic, written apart from the design's ALU
  // ------------------------------------------------------------
  // Bit 8 is the carry (borrow for subtracts)
  function automatic logic [8:0] alu(logic [7:0] a, logic [7:0] b,
                                     logic c, alu_fn_t fn);
    case (fn)
      ALU_ADD: return {1'b0, a} + {1'b0, b};
      ALU_ADC: return {1'b0, a} + {1'b0, b} + {8'h00, c};
      ALU_SUB: return {1'b0, a} - {1'b0, b};
      ALU_SBB: return {1'b0, a} - {1'b0, b} - {8'h00, c};
      ALU_AND: return {c, a & b};
      ALU_OR:  return {c, a | b};
      ALU_XOR: return {c, a ^ b};
      // Shifts act on the source byte, not on the destination
      ALU_ASL: return {b, 1'b0};
      ALU_ASR: return {b[0], b[7], b[7:1]};
      ALU_RLC: return {b, c};
      ALU_RRC: return {b[0], c, b[7:1]};
      default: return {c, b};
    endcase
  endfunction : alu

  function automatic logic [7:0] rb();
    return 8'($urandom);
  endfunction : rb

  // ------------------------------------------------------------
  // Driver: one cycle of stimulus plus its expected outcome
  // ------------------------------------------------------------
  // Side inputs are random so every port is exercised each cycle
  task automatic step(input logic rn, input logic v, input op_t o,
                      input alu_fn_t fn, input logic [7:0] s);
    note_t       n;
    logic [8:0]  r;
    logic [7:0]  opd, ra;
    logic [15:0] jt;
    logic [1:0]  len;
    logic        ix, se, sx, irq, ren;
    opd = rb();
    jt  = 16'($urandom);
    len = 2'($urandom);
    ix  = 1'($urandom);
    se  = ($urandom % 8) == 0;
    sx  = ($urandom % 8) == 0;
    irq = 1'($urandom);
    ren = 1'($urandom);
    ra  = 1'($urandom) ? `CRS_FLAGS_ADDR : rb();
    rstn <= rn; op_valid <= v; op_code <= o; alu_fn <= fn;
    operand <= opd; op_indexed <= ix; src_data <= s;
    jump_target <= jt; instr_len <= len; super_enter <= se;
    super_exit <= sx; irq_pending <= irq; reg_rd_en <= ren;
    reg_rd_addr <= ra;
    n.a = ma; n.x = mx; n.sp = msp; n.f = mf; n.pc = mpc;
    n.irq = irq & mf[`CRS_F_GIE];
    n.oa = opd + (ix ? mx : 8'h00);
    // Only the flags answer at their fixed address
    n.rd = ren ? ((ra == `CRS_FLAGS_ADDR) ? mf : 8'h00) : mrd;
    r = alu((o == OP_ALU_X) ? mx : ma, s, mf[`CRS_F_CARRY], fn);
    if (v) begin
      if (o inside {OP_CALL, OP_LCALL, OP_JMP, OP_RET, OP_RETI})
        n.pc = jt;
      else
        n.pc = mpc + 16'(len);
      case (o)
        OP_ALU_A, OP_ALU_X: begin
          if (o == OP_ALU_A) n.a = r[7:0];
          else n.x = r[7:0];
          // MOV leaves both status flags alone
          if (fn != ALU_MOV) begin
            n.f[`CRS_F_ZERO]  = (r[7:0] == 8'h00);
            n.f[`CRS_F_CARRY] = r[8];
          end
        end
        OP_MOV_X:         n.x = s;
        OP_PUSH:          n.sp = msp + `CRS_SP_PUSH;
        OP_POP: begin
          n.sp = msp - `CRS_SP_PUSH;
          n.a  = s;
        end
        OP_CALL, OP_LCALL: n.sp = msp + `CRS_SP_CALL;
        OP_RET:           n.sp = msp - `CRS_SP_RET;
        OP_RETI:          n.sp = msp - `CRS_SP_RETI;
        OP_ADD_SP:        n.sp = msp + s;
        OP_SWAP_SP: begin
          n.a  = msp;
          n.sp = ma;
        end
        OP_OR_F:          n.f = mf | (s & `CRS_F_WR_MASK);
        OP_AND_F:         n.f = mf & (s | ~`CRS_F_WR_MASK);
        default: ;
      endcase
    end
    // Supervisor bit follows the hardware pins only, enter wins
    if (se) n.f[`CRS_F_SUPER] = 1'b1;
    else if (sx) n.f[`CRS_F_SUPER] = 1'b0;
    if (!rn) begin
      n.a = `CRS_BYTE_RST; n.x = `CRS_BYTE_RST; n.sp = `CRS_BYTE_RST;
      n.f = `CRS_FLAGS_RST; n.pc = `CRS_PC_RST; n.oa = 8'h00;
      n.rd = 8'h00; n.irq = 1'b0;
    end
    ma = n.a; mx = n.x; msp = n.sp; mf = n.f; mpc = n.pc; mrd = n.rd;
    n.due = cyc + 2;
    q.push_back(n);
    @(posedge sys_clk);
  endtask : step

  // ------------------------------------------------------------
  // Monitor: settled outputs against the oldest due note
  // ------------------------------------------------------------
  always @(negedge sys_clk) begin
    cyc++;
    while (q.size() > 0 && q[0].due <= cyc) begin
      mon_n = q.pop_front();
      `CHK(acc, mon_n.a)
      `CHK(idx_q, mon_n.x)
      `CHK(sp_q, mon_n.sp)
      `CHK(flg, mon_n.f)
      `CHK(flg[2:1], mon_n.f[2:1])
      `CHK(flg[4:0], mon_n.f[4:0])
      `CHK({pch, pcl}, mon_n.pc)
      `CHK(pa_q, mon_n.pc[12:0])
      `CHK(oa_q, mon_n.oa)
      `CHK(gie_q, mon_n.f[`CRS_F_GIE])
      `CHK(irq_q, mon_n.irq)
      `CHK(bank_q, mon_n.f[`CRS_F_BANK])
      `CHK(rd_q, mon_n.rd)
    end
  end

  task automatic test_done();
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // Watchdog: the sequence needs about 2100 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    test_done();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0; op_valid = 1'b0; op_code = OP_NOP; alu_fn = ALU_MOV;
    operand = 8'h00; op_indexed = 1'b0; src_data = 8'h00;
    jump_target = 16'h0000; instr_len = 2'h0; super_enter = 1'b0;
    super_exit = 1'b0; irq_pending = 1'b0; reg_rd_en = 1'b0;
    reg_rd_addr = 8'h00;
    void'($urandom(32'h5C1744BD));
    @(posedge sys_clk);
    repeat (20) step(1'b0, 1'b0, OP_NOP, ALU_MOV, 8'h00);
    step(1'b1, 1'b0, OP_NOP, ALU_MOV, 8'h00);
    // Every instruction class, back to back
    for (int i = 0; i < 15; i++) step(1'b1, 1'b1, op_t'(i), ALU_ADD, rb());
    // Every ALU function into both destinations
    for (int i = 0; i < 12; i++) begin
      step(1'b1, 1'b1, OP_ALU_A, alu_fn_t'(i), rb());
      step(1'b1, 1'b1, OP_ALU_X, alu_fn_t'(i), rb());
    end
    // Zero result, then an add that wraps with a carry out
    step(1'b1, 1'b1, OP_ALU_A, ALU_XOR, ma);
    step(1'b1, 1'b1, OP_ALU_A, ALU_MOV, 8'hFF);
    step(1'b1, 1'b1, OP_ALU_A, ALU_ADD, 8'h01);
    // Attempt to set and clear every flag bit, super included
    step(1'b1, 1'b1, OP_OR_F, ALU_MOV, 8'hFF);
    step(1'b1, 1'b1, OP_AND_F, ALU_MOV, 8'h00);
    repeat (2000)
      step(1'b1, ($urandom % 4) != 0, op_t'($urandom % 15),
           alu_fn_t'($urandom % 12), rb());
    // Reset in mid-run with an op present, then resume
    step(1'b0, 1'b1, OP_PUSH, ALU_MOV, rb());
    step(1'b1, 1'b0, OP_NOP, ALU_MOV, 8'h00);
    repeat (20) step(1'b1, 1'b1, op_t'($urandom % 15), ALU_ADC, rb());
    repeat (3) step(1'b1, 1'b0, OP_NOP, ALU_MOV, 8'h00);
    test_done();
  end

endmodule : tb_cpu_core_register_set
